// ==== inc/flash_isp_consts.svh ====
`ifndef FLASH_ISP_CONSTS_SVH
`define FLASH_ISP_CONSTS_SVH
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_ADDR 12'h004
`define OFF_DATA 12'h008
`define OFF_CMD  12'h00c
`define OFF_TRIG 12'h010
`define OFF_DFB  12'h014
`define OFF_FAW  12'h018
// control register fields
`define CTL_EN     0
`define CTL_BS     1
`define CTL_CFGU   4
`define CTL_LDU    5
`define CTL_FF     6
`define CTL_PT_LSB 8
`define CTL_ET_LSB 12
`define TRG_GO     0
`define FAW_W      4
`define CMD_W      6
// unlock byte sequence
`define UNLOCK_B1 8'h59
`define UNLOCK_B2 8'h16
`define UNLOCK_B3 8'h88
// command codes
`define CMD_READ  6'h00
`define CMD_PROG  6'h21
`define CMD_ERASE 6'h22
// configuration word fields
`define CFGA_DATA_FLASH_DISABLE_N  0
`define CFGA_LOCK  1
`define CFGA_CBS   7
`define CFGA_BORST 20
`define CFGA_BOV   22:21
`define CFGA_BODEN 23
`define CFGA_OSC   26:24
`define CFGA_CKF   28
`define CFGB_DFB   19:0
`define CFG_ERASED 32'hffff_ffff
// address map
`define PF_END     32'h0002_0000
`define LDR_BASE   32'h0010_0000
`define LDR_END    32'h0010_1000
`define CFG_LAST   20'h0_0004
`define SMALL_DFB  32'h0001_f000
// timing
`define CLK_MHZ      50
`define CYC_PER_US   (`CLK_MHZ)
`define CYC_PER_MS   (`CLK_MHZ * 1000)
`define READ_TIME_NS 40
`define READ_CYC     ((`READ_TIME_NS * `CLK_MHZ + 999) / 1000)
`define ET_BASE_MS   20
`define ET_FAST_MS   3
`define ET_STEP_MS   5
`define PT_BASE_US   40
`define PT_FAST_US   20
`define PT_STEP_US   5
`define TMR_W        21
`endif

// ==== inc/flash_isp_pkg.sv ====
`default_nettype none
package flash_isp_pkg;
  typedef logic [31:0] word_t;
  typedef logic [5:0]  cmd_t;
  typedef enum logic [1:0] {UL_IDLE, UL_GOT1, UL_GOT2, UL_OPEN} unlock_e;
  typedef enum logic {OP_IDLE, OP_RUN} op_e;
endpackage : flash_isp_pkg
`default_nettype wire

// ==== hdl/isp_op_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "flash_isp_consts.svh"
module isp_op_timer (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_start,
  input  wire logic [`TMR_W-1:0] i_cycles,
  output logic                   o_done
);
  import flash_isp_pkg::*;
  logic [`TMR_W-1:0] remain;

  // a zero request runs one cycle so the operation never hangs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      remain <= '0;
    end else if (i_start) begin
      remain <= (i_cycles == '0) ? `TMR_W'(1) : i_cycles;
    end else if (remain != '0) begin
      remain <= remain - `TMR_W'(1);
    end
  end

  assign o_done = (remain == `TMR_W'(1));

  a_done_single: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done |=> !o_done) else $error("timer done lasted two cycles");
endmodule : isp_op_timer
`default_nettype wire

// ==== hdl/flash_isp_controller.sv ====
// What this block does
// - Control writes take effect only after unlock bytes 59, 16, 88 in order.
// - On trigger, errors are checked first; on error no start, fail flag sets.
// - Fail on self-write of program flash or loader, locked config, bad address.
// - Config erase or program refused and flagged while config update is off.
// - Fail flag sticky until software clears; new operations still start.
// - Writing 1 to the fail flag clears it; 0 leaves it.
// - CPU stalls while the trigger is set; peripherals run on.
// - Trigger clears itself on completion so software can poll it.
// - Loader updates allowed from program flash only with loader update enable.
// - Boot select takes inverted config boot bit on power-on reset only.
// - Software sets boot select and resets to boot from loader.
// - Config boot bit 0 boots loader, 1 boots program flash.
// - Config clock source copied into clock select after every reset.
// - Security lock 0 makes debug reads all ones except id and config.
// - Large part: data flash enable bit 0 enables region at configured base.
// - Brown-out reset and detect bits are active low enables.
// - Trigger write 1 starts; reads 1 while busy, 0 when done.
`timescale 1ns/10ps
`default_nettype none
`include "flash_isp_consts.svh"
module flash_isp_controller #(
  parameter int unsigned P_CYC_PER_MS = `CYC_PER_MS,
  parameter bit          P_LARGE_PART = 1'b1
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_por_rst,
  input  wire logic                 i_reg_sel,
  input  wire logic                 i_reg_wr,
  input  wire logic [11:0]          i_reg_addr,
  input  wire flash_isp_pkg::word_t i_reg_wdata,
  output flash_isp_pkg::word_t      o_reg_rdata,
  input  wire logic                 i_unlock_wr,
  input  wire logic [7:0]           i_unlock_data,
  output logic                      o_unlocked,
  input  wire flash_isp_pkg::word_t i_cfg_a,
  input  wire flash_isp_pkg::word_t i_cfg_b,
  output logic                      o_flash_start,
  output flash_isp_pkg::cmd_t       o_flash_cmd,
  output flash_isp_pkg::word_t      o_flash_addr,
  output flash_isp_pkg::word_t      o_flash_wdata,
  input  wire flash_isp_pkg::word_t i_flash_rdata,
  output logic                      o_cpu_stall,
  output logic                      o_boot_from_loader,
  output logic [2:0]                o_clk_sel,
  output logic                      o_xtal_filter_en,
  output logic                      o_bod_en,
  output logic                      o_bor_en,
  output logic [1:0]                o_bo_level,
  output logic                      o_df_en,
  output flash_isp_pkg::word_t      o_df_base,
  output logic [`FAW_W-1:0]         o_access_window,
  input  wire flash_isp_pkg::word_t i_dbg_rdata,
  input  wire logic                 i_dbg_id_or_cfg,
  output flash_isp_pkg::word_t      o_dbg_rdata
);
  import flash_isp_pkg::*;

  unlock_e           ul_state;
  op_e               op_state;
  word_t             isp_address, isp_data, cfg_a_q, cfg_b_q;
  cmd_t              isp_command;
  logic              prog_enable, config_update_enable, loader_update_enable;
  logic              op_fail_flag, boot_select_status, por_pend, load_done;
  logic [2:0]        erase_time_sel, program_time_sel;
  logic [`FAW_W-1:0] flash_access_window;
  logic [`TMR_W-1:0] op_cycles;
  logic              wr, ctrl_we, trig_req, trig_go, fail_set, fail_clr, tmr_done;
  logic              is_cfg, is_ldr, is_pf, in_df, is_write, cmd_ok, range_bad, fail_now;

  // erase time in ms from the select field
  function automatic int unsigned erase_ms(input logic [2:0] sel);
    if (sel[2]) begin
      erase_ms = (sel[1:0] == 2'b00) ? `ET_FAST_MS : `ET_STEP_MS * sel[1:0];
    end else begin
      erase_ms = `ET_BASE_MS + `ET_STEP_MS * sel[1:0];
    end
  endfunction : erase_ms

  // program time in us from the select field
  function automatic int unsigned prog_us(input logic [2:0] sel);
    prog_us = (sel[2] ? `PT_FAST_US : `PT_BASE_US) + `PT_STEP_US * sel[1:0];
  endfunction : prog_us

  // bus decode; writes are ignored while an operation runs
  assign wr       = i_reg_sel && i_reg_wr && (op_state == OP_IDLE);
  assign ctrl_we  = wr && (i_reg_addr == `OFF_CTRL) && (ul_state == UL_OPEN);
  assign trig_req = wr && (i_reg_addr == `OFF_TRIG) && i_reg_wdata[`TRG_GO] && prog_enable;
  assign o_unlocked = (ul_state == UL_OPEN);

  // ordered unlock sequence; any write while open locks again
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ul_state <= UL_IDLE;
    end else if (i_unlock_wr) begin
      case (ul_state)
        UL_IDLE: ul_state <= (i_unlock_data == `UNLOCK_B1) ? UL_GOT1 : UL_IDLE;
        UL_GOT1: ul_state <= (i_unlock_data == `UNLOCK_B2) ? UL_GOT2 : UL_IDLE;
        UL_GOT2: ul_state <= (i_unlock_data == `UNLOCK_B3) ? UL_OPEN : UL_IDLE;
        default: ul_state <= UL_IDLE;
      endcase
    end
  end

  assign cmd_ok   = (isp_command == `CMD_READ) || (isp_command == `CMD_PROG) ||
                    (isp_command == `CMD_ERASE);
  assign is_write = (isp_command == `CMD_PROG) || (isp_command == `CMD_ERASE);
  assign is_cfg   = (isp_address[31:22] == '0) && isp_address[21] && isp_address[20];
  assign is_pf    = (isp_address < `PF_END);
  assign is_ldr   = (isp_address >= `LDR_BASE) && (isp_address < `LDR_END);
  assign in_df    = is_pf && o_df_en && (isp_address >= o_df_base);
  assign range_bad = is_cfg ? (isp_address[19:0] > `CFG_LAST) : !(is_pf || is_ldr);

  // error conditions; data flash stays writable from program flash
  always_comb begin
    fail_now = !cmd_ok || range_bad;
    if (is_write && is_pf && !in_df && !boot_select_status) begin
      fail_now = 1'b1;
    end
    if (is_write && is_ldr && (boot_select_status || !loader_update_enable)) begin
      fail_now = 1'b1;
    end
    if (is_write && is_cfg && !config_update_enable) begin
      fail_now = 1'b1;
    end
  end

  assign trig_go  = trig_req && !fail_now;
  assign fail_set = trig_req && fail_now;
  assign fail_clr = ctrl_we && i_reg_wdata[`CTL_FF];

  // operation length from the timing fields
  always_comb begin
    case (isp_command)
      `CMD_ERASE: op_cycles = `TMR_W'(erase_ms(erase_time_sel) * P_CYC_PER_MS);
      `CMD_PROG:  op_cycles = `TMR_W'(prog_us(program_time_sel) * `CYC_PER_US);
      default:    op_cycles = `TMR_W'(`READ_CYC);
    endcase
  end

  isp_op_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (trig_go),
    .i_cycles   (op_cycles),
    .o_done     (tmr_done)
  );

  // run state is the trigger bit
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      op_state      <= OP_IDLE;
      o_flash_start <= 1'b0;
    end else begin
      o_flash_start <= trig_go;
      case (op_state)
        OP_IDLE: op_state <= trig_go ? OP_RUN : OP_IDLE;
        OP_RUN:  op_state <= tmr_done ? OP_IDLE : OP_RUN;
        default: op_state <= OP_IDLE;
      endcase
    end
  end

  // cpu held for the whole operation
  assign o_cpu_stall = (op_state == OP_RUN);

  // sticky fail flag; a new failure wins over a clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      op_fail_flag <= 1'b0;
    end else if (fail_set) begin
      op_fail_flag <= 1'b1;
    end else if (fail_clr) begin
      op_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prog_enable          <= 1'b0;
      config_update_enable <= 1'b0;
      loader_update_enable <= 1'b0;
      erase_time_sel       <= 3'h0;
      program_time_sel     <= 3'h0;
    end else if (ctrl_we) begin
      prog_enable          <= i_reg_wdata[`CTL_EN];
      config_update_enable <= i_reg_wdata[`CTL_CFGU];
      loader_update_enable <= i_reg_wdata[`CTL_LDU];
      erase_time_sel       <= i_reg_wdata[`CTL_ET_LSB+:3];
      program_time_sel     <= i_reg_wdata[`CTL_PT_LSB+:3];
    end
  end

  // access window field shares the same write protection
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flash_access_window <= '0;
    end else if (wr && (i_reg_addr == `OFF_FAW) && (ul_state == UL_OPEN)) begin
      flash_access_window <= i_reg_wdata[`FAW_W-1:0];
    end
  end
  assign o_access_window = flash_access_window;

  // address, data, command; read results land in the data register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      isp_address <= '0;
      isp_data    <= '0;
      isp_command <= `CMD_READ;
    end else begin
      if (wr && (i_reg_addr == `OFF_ADDR)) begin
        isp_address <= i_reg_wdata;
      end
      if (wr && (i_reg_addr == `OFF_CMD)) begin
        isp_command <= i_reg_wdata[`CMD_W-1:0];
      end
      if (wr && (i_reg_addr == `OFF_DATA)) begin
        isp_data <= i_reg_wdata;
      end else if (tmr_done && (isp_command == `CMD_READ)) begin
        isp_data <= i_flash_rdata;
      end
    end
  end
  assign o_flash_cmd   = isp_command;
  assign o_flash_addr  = isp_address;
  assign o_flash_wdata = isp_data;

  // configuration copy after every reset release; flash reads as erased until then
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      load_done <= 1'b0;
      cfg_a_q   <= `CFG_ERASED;
      cfg_b_q   <= `CFG_ERASED;
      o_clk_sel <= 3'h0;
    end else if (!load_done) begin
      load_done <= 1'b1;
      cfg_a_q   <= i_cfg_a;
      cfg_b_q   <= i_cfg_b;
      o_clk_sel <= i_cfg_a[`CFGA_OSC];
    end
  end

  // boot select survives ordinary resets; only power-on reset clears it
  always_ff @(posedge i_core_clk or posedge i_por_rst) begin
    if (i_por_rst) begin
      por_pend           <= 1'b1;
      boot_select_status <= 1'b0;
    end else if (!load_done && !i_rst) begin
      por_pend <= 1'b0;
      if (por_pend) begin
        boot_select_status <= !i_cfg_a[`CFGA_CBS];
      end
    end else if (ctrl_we) begin
      boot_select_status <= i_reg_wdata[`CTL_BS];
    end
  end
  assign o_boot_from_loader = boot_select_status;

  assign o_bod_en         = !cfg_a_q[`CFGA_BODEN];
  assign o_bor_en         = !cfg_a_q[`CFGA_BORST];
  assign o_bo_level       = cfg_a_q[`CFGA_BOV];
  assign o_xtal_filter_en = cfg_a_q[`CFGA_CKF];
  assign o_df_en   = P_LARGE_PART ? !cfg_a_q[`CFGA_DATA_FLASH_DISABLE_N] : 1'b1;
  assign o_df_base = P_LARGE_PART ? {12'h000, cfg_b_q[`CFGB_DFB]} : `SMALL_DFB;

  // debug read masking; the isp path is never masked
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dbg_rdata <= '0;
    end else if (!cfg_a_q[`CFGA_LOCK] && !i_dbg_id_or_cfg) begin
      o_dbg_rdata <= '1;
    end else begin
      o_dbg_rdata <= i_dbg_rdata;
    end
  end

  // registered read port, unmapped offsets read zero
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_sel && !i_reg_wr) begin
      case (i_reg_addr)
        `OFF_CTRL: begin
          o_reg_rdata                   <= '0;
          o_reg_rdata[`CTL_EN]          <= prog_enable;
          o_reg_rdata[`CTL_BS]          <= boot_select_status;
          o_reg_rdata[`CTL_CFGU]        <= config_update_enable;
          o_reg_rdata[`CTL_LDU]         <= loader_update_enable;
          o_reg_rdata[`CTL_FF]          <= op_fail_flag;
          o_reg_rdata[`CTL_PT_LSB+:3]   <= program_time_sel;
          o_reg_rdata[`CTL_ET_LSB+:3]   <= erase_time_sel;
        end
        `OFF_ADDR: o_reg_rdata <= isp_address;
        `OFF_DATA: o_reg_rdata <= isp_data;
        `OFF_CMD:  o_reg_rdata <= {26'h0, isp_command};
        `OFF_TRIG: o_reg_rdata <= {31'h0, o_cpu_stall};
        `OFF_DFB:  o_reg_rdata <= o_df_base;
        `OFF_FAW:  o_reg_rdata <= {28'h0, flash_access_window};
        default:   o_reg_rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_locked_ctrl_write: assert property (
    (wr && (i_reg_addr == `OFF_CTRL) && !o_unlocked) |=> $stable(prog_enable) && $stable(erase_time_sel))
    else $error("control changed while locked");
  a_error_no_start: assert property (
    fail_set |=> !o_cpu_stall && op_fail_flag && !o_flash_start)
    else $error("operation started despite error");
  a_bad_range_fails: assert property (
    (trig_req && range_bad) |=> op_fail_flag && !o_cpu_stall)
    else $error("illegal address not flagged");
  a_cfg_write_refused: assert property (
    (trig_req && is_cfg && is_write && !config_update_enable) |=> op_fail_flag && !o_flash_start)
    else $error("locked config write accepted");
  a_fail_sticky: assert property (
    (op_fail_flag && !fail_clr) |=> op_fail_flag)
    else $error("fail flag lost without clear");
  a_fail_clear: assert property (
    (fail_clr && !fail_set) |=> !op_fail_flag)
    else $error("write one did not clear fail flag");
  a_read_length: assert property (
    (trig_go && (isp_command == `CMD_READ)) |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("read stall length wrong");
  a_done_clears_trig: assert property (
    tmr_done |=> !o_cpu_stall ##0 (isp_command != `CMD_READ || isp_data == $past(i_flash_rdata)))
    else $error("trigger not cleared at completion");
  a_loader_refused: assert property (
    (trig_req && is_ldr && is_write && !loader_update_enable) |=> op_fail_flag && !o_cpu_stall)
    else $error("loader update not refused");
  a_clk_sel_load: assert property (
    !load_done |=> (o_clk_sel == $past(i_cfg_a[`CFGA_OSC])))
    else $error("clock source not copied");
  a_debug_mask: assert property (
    (!cfg_a_q[`CFGA_LOCK] && !i_dbg_id_or_cfg) |=> (o_dbg_rdata == '1))
    else $error("locked debug read not masked");

  c_read_op:  cover property (trig_go && (isp_command == `CMD_READ));
  c_erase_op: cover property (trig_go && (isp_command == `CMD_ERASE));
  c_fail_op:  cover property (fail_set);
  c_unlock:   cover property ($rose(o_unlocked));
endmodule : flash_isp_controller
`default_nettype wire

// ==== tb/flash_macro_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "flash_isp_consts.svh"
module flash_macro_model (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_start,
  input  wire flash_isp_pkg::cmd_t  i_cmd,
  input  wire flash_isp_pkg::word_t i_addr,
  input  wire flash_isp_pkg::word_t i_wdata,
  output var  flash_isp_pkg::word_t o_rdata
);
  import flash_isp_pkg::*;
  word_t mem [word_t];
  int    hold;
  // words absent from the array read as erased
  initial begin
    o_rdata = 32'h0;
    hold = 0;
  end
  // cell array: programming only clears bits
  always @(posedge i_core_clk) begin
    if (i_start) begin
      case (i_cmd)
        `CMD_PROG: mem[i_addr] = mem.exists(i_addr) ? (mem[i_addr] & i_wdata) : i_wdata;
        `CMD_ERASE: for (int j = 0; j < 128; j++) mem.delete({i_addr[31:9], j[6:0], 2'b00});
        default: ;
      endcase
    end
    // data held three cycles, then scrambled so a late sample shows up
    if (i_start && i_cmd == `CMD_READ) begin
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 32'hffff_ffff;
      hold <= 2;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule : flash_macro_model
`default_nettype wire

// ==== tb/flash_isp_controller_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "flash_isp_consts.svh"
module flash_isp_controller_tb_top;
  import flash_isp_pkg::*;
  localparam int unsigned P_MS = 5;
  logic        i_core_clk, i_rst, i_por_rst, i_reg_sel, i_reg_wr, i_unlock_wr, i_dbg_id_or_cfg;
  logic [11:0] i_reg_addr;
  logic [7:0]  i_unlock_data;
  word_t       i_reg_wdata, i_cfg_a, i_cfg_b, i_dbg_rdata, i_flash_rdata, o_reg_rdata;
  word_t       o_flash_addr, o_flash_wdata, o_df_base, o_dbg_rdata, r;
  cmd_t        o_flash_cmd;
  logic        o_unlocked, o_flash_start, o_cpu_stall, o_boot_from_loader, o_xtal_filter_en;
  logic        o_bod_en, o_bor_en, o_df_en, exp_ff;
  logic [2:0]  o_clk_sel;
  logic [1:0]  o_bo_level;
  logic [3:0]  o_access_window;
  int          failures, tests_run, n;
  int unsigned pt_us [8] = '{40, 45, 50, 55, 20, 25, 30, 35};
  int unsigned et_ms [8] = '{20, 25, 30, 35, 3, 5, 10, 15};

  flash_isp_controller #(.P_CYC_PER_MS(P_MS)) u_dut (
    .i_core_clk, .i_rst, .i_por_rst, .i_reg_sel, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_unlock_wr, .i_unlock_data, .o_unlocked, .i_cfg_a, .i_cfg_b,
    .o_flash_start, .o_flash_cmd, .o_flash_addr, .o_flash_wdata, .i_flash_rdata,
    .o_cpu_stall, .o_boot_from_loader, .o_clk_sel, .o_xtal_filter_en, .o_bod_en, .o_bor_en,
    .o_bo_level, .o_df_en, .o_df_base, .o_access_window, .i_dbg_rdata, .i_dbg_id_or_cfg,
    .o_dbg_rdata
  );
  flash_macro_model u_flash (
    .i_core_clk, .i_start(o_flash_start), .i_cmd(o_flash_cmd), .i_addr(o_flash_addr),
    .i_wdata(o_flash_wdata), .o_rdata(i_flash_rdata)
  );

  // free-running core clock
  always #10 i_core_clk = ~i_core_clk;

  task give_verdict;
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task chk(input word_t seen, input word_t exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // register cycles launched and released on falling edges
  task wr(input logic [11:0] a, input word_t d);
    @(negedge i_core_clk);
    i_reg_sel = 1'b1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_core_clk);
    i_reg_sel = 1'b0;
    i_reg_wr = 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, output word_t d);
    @(negedge i_core_clk);
    i_reg_sel = 1'b1;
    i_reg_addr = a;
    @(negedge i_core_clk);
    i_reg_sel = 1'b0;
    d = o_reg_rdata;
  endtask : rd

  task unl(input logic [7:0] b);
    @(negedge i_core_clk);
    i_unlock_wr = 1'b1;
    i_unlock_data = b;
    @(negedge i_core_clk);
    i_unlock_wr = 1'b0;
  endtask : unl

  task unlock_all;
    unl(`UNLOCK_B1);
    unl(`UNLOCK_B2);
    unl(`UNLOCK_B3);
  endtask : unlock_all

  // full operation: set up, trigger, time the stall, then check flag and trigger
  task op(input word_t ctl, input word_t a, input cmd_t c, input logic f, input int unsigned cyc);
    wr(`OFF_CTRL, ctl);
    wr(`OFF_ADDR, a);
    wr(`OFF_DATA, a ^ 32'h5a5a_0000);
    wr(`OFF_CMD, {26'h0, c});
    wr(`OFF_TRIG, 32'h1);
    chk({31'h0, o_flash_start}, {31'h0, !f});
    // no further access until the stall drops
    n = 0;
    while (o_cpu_stall === 1'b1 && n < 5000) begin
      n++;
      @(negedge i_core_clk);
    end
    if (n >= 5000) begin
      failures++;
      give_verdict();
    end
    chk(word_t'(n), f ? 32'h0 : word_t'(cyc));
    exp_ff = exp_ff | f;
    rd(`OFF_CTRL, r);
    chk({31'h0, r[`CTL_FF]}, {31'h0, exp_ff});
    rd(`OFF_TRIG, r);
    chk(r, 32'h0);
  endtask : op

  task do_reset(input logic por);
    i_rst = 1'b1;
    i_por_rst = por;
    repeat (16) @(negedge i_core_clk);
    i_rst = 1'b0;
    i_por_rst = 1'b0;
    repeat (2) @(negedge i_core_clk);
  endtask : do_reset

  // main sequence
  initial begin
    i_core_clk = 1'b0;
    i_reg_sel = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_addr = 12'h000;
    i_reg_wdata = 32'h0;
    i_unlock_wr = 1'b0;
    i_unlock_data = 8'h00;
    i_dbg_rdata = 32'h1234_5678;
    i_dbg_id_or_cfg = 1'b0;
    i_cfg_a = 32'h0740_0080;
    i_cfg_b = 32'h0001_e000; // low nine and reserved bits zero
    failures = 0;
    tests_run = 0;
    exp_ff = 1'b0;
    do_reset(1'b1);
    chk({22'h0, o_clk_sel, o_bod_en, o_bor_en, o_bo_level, o_df_en, o_boot_from_loader,
         o_xtal_filter_en}, 32'h3f4);
    chk(o_df_base, 32'h0001_e000);
    chk(o_dbg_rdata, 32'hffff_ffff);
    i_dbg_id_or_cfg = 1'b1;
    @(negedge i_core_clk);
    chk(o_dbg_rdata, 32'h1234_5678);
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4), r);
      chk(r, (i == 5) ? 32'h0001_e000 : 32'h0);
    end
    // locked writes and a broken unlock sequence
    wr(`OFF_CTRL, 32'h1);
    unl(`UNLOCK_B1);
    unl(`UNLOCK_B3);
    wr(`OFF_CTRL, 32'h1);
    rd(`OFF_CTRL, r);
    chk(r, 32'h0);
    unlock_all();
    chk({31'h0, o_unlocked}, 32'h1);
    wr(`OFF_FAW, 32'hf);
    rd(`OFF_FAW, r);
    chk(r, 32'hf);
    wr(`OFF_DFB, 32'h0);
    rd(`OFF_DFB, r);
    chk(r, 32'h0001_e000);
    wr(`OFF_CTRL, 32'h7731);
    rd(`OFF_CTRL, r);
    chk(r, 32'h7731);
    op(32'h1, 32'h100, `CMD_READ, 1'b0, 2);
    rd(`OFF_DATA, r);
    chk(r, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      op(32'h1 | (i << 8), 32'h1e000 + i * 4, `CMD_PROG, 1'b0, pt_us[i] * `CYC_PER_US);
    end
    op(32'h1, 32'h1e008, `CMD_READ, 1'b0, 2);
    rd(`OFF_DATA, r);
    chk(r, 32'h5a5b_e008);
    for (int i = 0; i < 8; i++) begin
      op(32'h1 | (i << 12), 32'h1e200, `CMD_ERASE, 1'b0, et_ms[i] * P_MS);
    end
    // refusals, sticky flag and its clearing
    op(32'h1, 32'h100, `CMD_PROG, 1'b1, 0);
    op(32'h1, 32'h100, `CMD_READ, 1'b0, 2);
    wr(`OFF_CTRL, 32'h41);
    exp_ff = 1'b0;
    rd(`OFF_CTRL, r);
    chk(r, 32'h1);
    op(32'h1, 32'h30_0000, `CMD_PROG, 1'b1, 0);
    op(32'h11, 32'h30_0004, `CMD_PROG, 1'b0, 40 * `CYC_PER_US);
    op(32'h1, 32'h5_0000, `CMD_READ, 1'b1, 0);
    op(32'h1, 32'h10_0000, `CMD_PROG, 1'b1, 0);
    op(32'h21, 32'h10_0000, `CMD_PROG, 1'b0, 40 * `CYC_PER_US);
    op(32'h1, 32'h0, 6'h3f, 1'b1, 0);
    // boot from loader through a plain reset
    wr(`OFF_CTRL, 32'h43);
    exp_ff = 1'b0;
    // reserved clock code passes through; boot bit would give 0 if reloaded
    i_cfg_a = 32'h0140_0080;
    do_reset(1'b0);
    chk({29'h0, o_clk_sel}, 32'h1);
    chk({31'h0, o_boot_from_loader}, 32'h1);
    rd(`OFF_CTRL, r);
    chk(r, 32'h2);
    unlock_all();
    op(32'h3, 32'h100, `CMD_PROG, 1'b0, 40 * `CYC_PER_US);
    op(32'h23, 32'h10_0000, `CMD_PROG, 1'b1, 0);
    // power-on reloads boot select and clock source
    i_cfg_a = 32'h1040_0080;
    do_reset(1'b1);
    chk({22'h0, o_clk_sel, o_bod_en, o_bor_en, o_bo_level, o_df_en, o_boot_from_loader,
         o_xtal_filter_en}, 32'h075);
    // trigger ignored while programming is disabled after reset
    wr(`OFF_TRIG, 32'h1);
    chk({31'h0, o_flash_start}, 32'h0);
    rd(`OFF_TRIG, r);
    chk(r, 32'h0);
    rd(`OFF_CTRL, r);
    chk(r, 32'h0);
    give_verdict();
  end
endmodule : flash_isp_controller_tb_top
`default_nettype wire
